// >>> design/mgp_pkg.sv
`default_nettype none
package mgp_pkg;
  localparam int NUM_PINS = 16;
  localparam int FUNC_W = 3;
  localparam int OBS_W = 4;
  localparam int RATE_W = 2;
  localparam logic [4:0] CFG_DEVICE_GROUP = 5'h1e;
  localparam logic [15:0] CFG_FIRST_REG = 16'h0100;
  // Function codes of the first configuration register.
  localparam logic [2:0] FN_PLAIN_IO = 3'h0;
  localparam logic [2:0] FN_OBSERVE = 3'h1;
  localparam logic [2:0] FN_SLAVE_TWI = 3'h2;
  localparam logic [2:0] FN_MODULE_TWI = 3'h3;
  localparam logic [2:0] FN_ALT_A = 3'h4;
  localparam logic [2:0] FN_ALT_B = 3'h5;
  localparam logic [2:0] FN_ALT_C = 3'h6;
  localparam logic [2:0] FN_ALT_D = 3'h7;
  // Plain I/O modes.
  localparam logic [1:0] IO_INPUT = 2'h0;
  localparam logic [1:0] IO_DRIVE = 2'h1;
  localparam logic [1:0] IO_LED = 2'h2;
  localparam int SLAVE_DATA_PIN = 2;
  localparam int SLAVE_CLK_PIN = 3;
  localparam int MOD0_DATA_PIN = 6;
  localparam int MOD0_CLK_PIN = 7;
  localparam int MOD1_DATA_PIN = 10;
  localparam int MOD1_CLK_PIN = 11;
  // Blink half periods in ms, converted to 100 MHz cycles.
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_MS0 = 50;
  localparam int BLINK_MS1 = 100;
  localparam int BLINK_MS2 = 250;
  localparam int BLINK_MS3 = 500;
  localparam int BLINK_CYC0 = BLINK_MS0 * (CLK_HZ / 1000);
  localparam int BLINK_CYC1 = BLINK_MS1 * (CLK_HZ / 1000);
  localparam int BLINK_CYC2 = BLINK_MS2 * (CLK_HZ / 1000);
  localparam int BLINK_CYC3 = BLINK_MS3 * (CLK_HZ / 1000);
  localparam int BLINK_W = 26;
endpackage
`default_nettype wire

// >>> design/mgp_sync.sv
`default_nettype none
module mgp_sync
  import mgp_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] change_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;

  // The first stage feeds only the second; the filtered level moves when stages two and
  // three agree, so a single metastable sample cannot count as a change.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= '1;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level_out = lvl_q;
  assign change_out = lvl_q ^ (s2_q & s3_q | ~s2_q & ~s3_q & lvl_q) & ~(s2_q ^ s3_q)
                      ^ (lvl_q & (s2_q ^ s3_q));
endmodule
`default_nettype wire

// >>> design/mgp_gpio_bank.sv
`default_nettype none
// Contract
// - Pins bidirectional, open drain, pull low only.
// - Two configuration registers select each pin function.
// - Pin 2 resets to slave two-wire data.
// - Pin 3 resets to slave two-wire clock.
// - Plain I/O drives low or releases high.
// - Plain I/O also samples input or blinks LED.
// - Enabled input change sets interrupt pending.
// - Observe function enables output driver automatically.
// - Second register selects observed internal signal.
// - Module masters use pins 6/7 and 10/11.
// - Registers in group 0x1E from 0x0100.
module mgp_gpio_bank
  import mgp_pkg::*;
#(
  parameter int PINS = NUM_PINS,
  parameter int BLINK_HALF0 = BLINK_CYC0,
  parameter int BLINK_HALF1 = BLINK_CYC1,
  parameter int BLINK_HALF2 = BLINK_CYC2,
  parameter int BLINK_HALF3 = BLINK_CYC3
) (
  input wire logic clock,
  input wire logic rst_n,
  // Configuration write port: one pin at a time, both registers together.
  input wire logic cfg_we,
  input wire logic [3:0] cfg_pin,
  input wire logic [FUNC_W-1:0] cfg_func,
  input wire logic [RATE_W-1:0] cfg_io_mode,
  input wire logic cfg_drive_high,
  input wire logic [RATE_W-1:0] cfg_blink_rate,
  input wire logic cfg_irq_en,
  input wire logic [OBS_W-1:0] cfg_obs_sel,
  // Pending clear, one bit per pin; a change in the same cycle wins.
  input wire logic [PINS-1:0] pend_clr,
  output logic [PINS-1:0] pend,
  output logic irq_any,
  output logic [PINS-1:0] pin_level,
  output logic [PINS*FUNC_W-1:0] func_state,
  // Internal signals.
  input wire logic [(1<<OBS_W)-1:0] observe_bus,
  input wire logic slave_sda_out,
  output logic slave_sda_in,
  output logic slave_scl_in,
  input wire logic [1:0] mod_sda_out,
  input wire logic [1:0] mod_scl_out,
  output logic [1:0] mod_sda_in,
  output logic [1:0] mod_scl_in,
  input wire logic [PINS-1:0] alt_out,
  output logic module_absent_input,
  // Pins: output value is always 0, enable low means driving low.
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n
);
  logic [FUNC_W-1:0] func_q [PINS];
  logic [RATE_W-1:0] mode_q [PINS];
  logic [PINS-1:0] drive_high_q;
  logic [RATE_W-1:0] rate_q [PINS];
  logic [PINS-1:0] irq_en_q;
  logic [OBS_W-1:0] obs_q [PINS];
  logic [PINS-1:0] pend_q;
  logic [PINS-1:0] level;
  logic [PINS-1:0] change;
  logic [BLINK_W-1:0] blink_cnt_q [4];
  logic [3:0] blink_q;
  logic [PINS-1:0] want_low;

  function automatic logic [FUNC_W-1:0] reset_func(input int idx);
    if (idx == SLAVE_DATA_PIN || idx == SLAVE_CLK_PIN) begin
      return FN_SLAVE_TWI;
    end
    return FN_PLAIN_IO;
  endfunction

  function automatic logic [BLINK_W-1:0] half_of(input int r);
    case (r)
      0: return BLINK_W'(BLINK_HALF0);
      1: return BLINK_W'(BLINK_HALF1);
      2: return BLINK_W'(BLINK_HALF2);
      default: return BLINK_W'(BLINK_HALF3);
    endcase
  endfunction

  // Configuration registers; the write port stands for the register pair at
  // device group 0x1e, register 0x0100 onward, decoded outside this block.
  // A write that names a pin beyond the bank is dropped rather than aliased onto another pin.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PINS; i++) begin
        func_q[i] <= reset_func(i);
        mode_q[i] <= IO_INPUT;
        rate_q[i] <= '0;
        obs_q[i] <= '0;
      end
      drive_high_q <= '1;
      irq_en_q <= '0;
    end else if (cfg_we && int'(cfg_pin) < PINS) begin
      func_q[cfg_pin] <= cfg_func;
      mode_q[cfg_pin] <= cfg_io_mode;
      drive_high_q[cfg_pin] <= cfg_drive_high;
      rate_q[cfg_pin] <= cfg_blink_rate;
      irq_en_q[cfg_pin] <= cfg_irq_en;
      obs_q[cfg_pin] <= cfg_obs_sel;
    end
  end

  mgp_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(pin_in),
    .level_out(level),
    .change_out()
  );

  // Change detection compares the filtered level with its value one cycle earlier; both
  // reset to the pulled-up idle level, so leaving reset raises no false change.
  logic [PINS-1:0] prev_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '1;
    end else begin
      prev_q <= level;
    end
  end
  assign change = level ^ prev_q;

  // A change in the same cycle as a clear sets the bit, so no event is lost.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (func_q[i] == FN_PLAIN_IO && mode_q[i] == IO_INPUT && irq_en_q[i] && change[i]) begin
          pend_q[i] <= 1'b1;
        end else if (pend_clr[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Four shared blink generators keep the counter cost independent of pin count.
  // They run free, so a pin just switched to LED mode may show one short first phase.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int r = 0; r < 4; r++) begin
        blink_cnt_q[r] <= '0;
      end
      blink_q <= '0;
    end else begin
      for (int r = 0; r < 4; r++) begin
        if (blink_cnt_q[r] >= half_of(r) - BLINK_W'(1)) begin
          blink_cnt_q[r] <= '0;
          blink_q[r] <= ~blink_q[r];
        end else begin
          blink_cnt_q[r] <= blink_cnt_q[r] + BLINK_W'(1);
        end
      end
    end
  end

  // A function that gives a pin no output role, such as the slave clock, leaves it released.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      want_low[i] = 1'b0;
      unique case (func_q[i])
        FN_PLAIN_IO: begin
          if (mode_q[i] == IO_DRIVE) begin
            want_low[i] = ~drive_high_q[i];
          end else if (mode_q[i] == IO_LED) begin
            want_low[i] = blink_q[rate_q[i]];
          end
        end
        FN_OBSERVE: want_low[i] = ~observe_bus[obs_q[i]];
        FN_SLAVE_TWI: begin
          if (i == SLAVE_DATA_PIN) begin
            want_low[i] = ~slave_sda_out;
          end
        end
        FN_MODULE_TWI: begin
          if (i == MOD0_DATA_PIN) want_low[i] = ~mod_sda_out[0];
          if (i == MOD0_CLK_PIN) want_low[i] = ~mod_scl_out[0];
          if (i == MOD1_DATA_PIN) want_low[i] = ~mod_sda_out[1];
          if (i == MOD1_CLK_PIN) want_low[i] = ~mod_scl_out[1];
        end
        FN_ALT_A, FN_ALT_B, FN_ALT_C, FN_ALT_D: want_low[i] = ~alt_out[i];
      endcase
    end
  end

  // Open drain: the pad only ever pulls low; high comes from the pull-up.
  // The enable is registered so that decode glitches never reach the pad.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_n <= '1;
    end else begin
      pin_oe_n <= ~want_low;
    end
  end
  assign pin_out = '0;

  // Slave two-wire inputs idle high when that function is unselected, as a released bus would; module inputs always follow the pin level.
  assign slave_sda_in = (func_q[SLAVE_DATA_PIN] == FN_SLAVE_TWI) ? level[SLAVE_DATA_PIN] : 1'b1;
  assign slave_scl_in = (func_q[SLAVE_CLK_PIN] == FN_SLAVE_TWI) ? level[SLAVE_CLK_PIN] : 1'b1;
  assign mod_sda_in = {level[MOD1_DATA_PIN], level[MOD0_DATA_PIN]};
  assign mod_scl_in = {level[MOD1_CLK_PIN], level[MOD0_CLK_PIN]};
  assign module_absent_input = level[0];
  assign pend = pend_q;
  assign irq_any = |pend_q;
  assign pin_level = level;

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      func_state[i*FUNC_W +: FUNC_W] = func_q[i];
    end
  end
endmodule
`default_nettype wire

// >>> tb/mgp_board.sv
`default_nettype none
module mgp_board (
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] ext_low,
  output logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups set the level; the device and the board only ever pull low.
  assign pin_in = pin_oe_n & ~ext_low;
endmodule
`default_nettype wire

// >>> tb/mgp_checker.sv
`default_nettype none
module mgp_checker
  import mgp_pkg::*;
#(
  parameter int PINS = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_pin,
  input wire logic [FUNC_W-1:0] cfg_func,
  input wire logic [RATE_W-1:0] cfg_io_mode,
  input wire logic cfg_drive_high,
  input wire logic [OBS_W-1:0] cfg_obs_sel,
  input wire logic [(1<<OBS_W)-1:0] observe_bus,
  input wire logic [PINS-1:0] pend,
  input wire logic irq_any,
  input wire logic [PINS-1:0] pin_level,
  input wire logic [PINS*FUNC_W-1:0] func_state,
  input wire logic slave_sda_out,
  input wire logic [1:0] mod_sda_out,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_od; pin_out == '0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_rst2; $rose(rst_n) |-> func_state[8:6] == FN_SLAVE_TWI; endproperty
  a_rst2: assert property (p_rst2) else $error("pin 2 reset func");
  property p_rst3; $rose(rst_n) |-> func_state[11:9] == FN_SLAVE_TWI; endproperty
  a_rst3: assert property (p_rst3) else $error("pin 3 reset func");
  property p_cfg; cfg_we |=> func_state[3*$past(cfg_pin) +: 3] == $past(cfg_func); endproperty
  a_cfg: assert property (p_cfg) else $error("func not stored");
  property p_drv;
    cfg_we && cfg_func == FN_PLAIN_IO && cfg_io_mode == IO_DRIVE ##1 !cfg_we
      |=> pin_oe_n[$past(cfg_pin, 2)] == $past(cfg_drive_high, 2);
  endproperty
  a_drv: assert property (p_drv) else $error("drive level wrong");
  property p_obs;
    cfg_we && cfg_func == FN_OBSERVE ##1 $stable(observe_bus) [*2]
      |-> pin_oe_n[$past(cfg_pin, 2)] == observe_bus[$past(cfg_obs_sel, 2)];
  endproperty
  a_obs: assert property (p_obs) else $error("observe output wrong");
  property p_irq; irq_any == |pend; endproperty
  a_irq: assert property (p_irq) else $error("irq not OR of pend");
  property p_pend; (pend & ~$past(pend) & ~(pin_level ^ $past(pin_level, 2))) == '0; endproperty
  a_pend: assert property (p_pend) else $error("pend without change");
  property p_lvl; ((pin_level ^ $past(pin_level)) & (pin_level ^ $past(pin_in, 3))) == '0;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not from input");
  property p_sda;
    (func_state[8:6] == FN_SLAVE_TWI && $stable(slave_sda_out)) [*2]
      |-> pin_oe_n[2] == slave_sda_out;
  endproperty
  a_sda: assert property (p_sda) else $error("slave data pin wrong");
  property p_scl; (func_state[11:9] == FN_SLAVE_TWI) [*2] |-> pin_oe_n[3]; endproperty
  a_scl: assert property (p_scl) else $error("slave clock driven");
  property p_mod;
    (func_state[20:18] == FN_MODULE_TWI && $stable(mod_sda_out[0])) [*2]
      |-> pin_oe_n[6] == mod_sda_out[0];
  endproperty
  a_mod: assert property (p_mod) else $error("module data pin wrong");
  c_obs: cover property (cfg_we && cfg_func == FN_OBSERVE);
  c_pend: cover property (irq_any);
  c_mod: cover property (!pin_oe_n[6]);
endmodule
bind mgp_gpio_bank mgp_checker #(.PINS(PINS)) u_chk (.clock(clock), .rst_n(rst_n),
  .cfg_we(cfg_we), .cfg_pin(cfg_pin), .cfg_func(cfg_func), .cfg_io_mode(cfg_io_mode),
  .cfg_drive_high(cfg_drive_high), .cfg_obs_sel(cfg_obs_sel), .observe_bus(observe_bus),
  .pend(pend), .irq_any(irq_any), .pin_level(pin_level), .func_state(func_state),
  .slave_sda_out(slave_sda_out), .mod_sda_out(mod_sda_out), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire

// >>> tb/mgp_gpio_bank_tb.sv
`default_nettype none
module mgp_gpio_bank_tb
  import mgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst_n = 0, we = 0, hi = 1, ie = 0, s_sda = 1, prv;
  logic [3:0] pin = 0, sel = 0;
  logic [2:0] fn = 0;
  logic [1:0] md = 0, rt = 0, m_sda = 2'h3, m_scl = 2'h3, msda_in, mscl_in;
  logic [15:0] clr = 0, ext = 0, obs = 0, alt = 16'hffff, pend, lvl, pin_in, oe_n;
  logic [47:0] fs;
  logic irq_any, ssda_in, sscl_in, mabs;
  int mismatches = 0, n_compared = 0, cyc = 0, cnt;
  mgp_gpio_bank #(.BLINK_HALF0(4), .BLINK_HALF1(8), .BLINK_HALF2(16), .BLINK_HALF3(32)) uut (
    .clock(clock), .rst_n(rst_n), .cfg_we(we), .cfg_pin(pin), .cfg_func(fn),
    .cfg_io_mode(md), .cfg_drive_high(hi), .cfg_blink_rate(rt), .cfg_irq_en(ie),
    .cfg_obs_sel(sel), .pend_clr(clr), .pend(pend), .irq_any(irq_any), .pin_level(lvl),
    .func_state(fs), .observe_bus(obs), .slave_sda_out(s_sda), .slave_sda_in(ssda_in),
    .slave_scl_in(sscl_in), .mod_sda_out(m_sda), .mod_scl_out(m_scl), .mod_sda_in(msda_in),
    .mod_scl_in(mscl_in), .alt_out(alt), .module_absent_input(mabs), .pin_in(pin_in),
    .pin_out(), .pin_oe_n(oe_n));
  mgp_board brd (.pin_oe_n(oe_n), .ext_low(ext), .pin_in(pin_in));
  initial forever #5 clock = ~clock;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [3:0] p, input logic [2:0] f, input logic [1:0] m,
      input logic h, input logic i, input logic [3:0] s, input logic [1:0] r);
    @(posedge clock);
    we <= 1;
    pin <= p;
    fn <= f;
    md <= m;
    hi <= h;
    ie <= i;
    sel <= s;
    rt <= r;
    @(posedge clock);
    we <= 0;
  endtask
  // Outputs are read at the falling edge so register updates have landed.
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic test_done();
    $display("mismatches=%0d compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    w(0);
    chk(fs[8:6], FN_SLAVE_TWI);
    chk(fs[11:9], FN_SLAVE_TWI);
    chk(fs[5:3], FN_PLAIN_IO);
    chk(oe_n, 16'hffff);
    cfg(5, FN_PLAIN_IO, IO_DRIVE, 0, 0, 0, 0);
    w(6);
    chk(lvl[5], 0);
    cfg(5, FN_PLAIN_IO, IO_DRIVE, 1, 0, 0, 0);
    w(6);
    chk(lvl[5], 1);
    // Pin 13 changes too but has its interrupt off, so only pin 12 may pend.
    cfg(12, FN_PLAIN_IO, IO_INPUT, 1, 1, 0, 0);
    cfg(13, FN_PLAIN_IO, IO_INPUT, 1, 0, 0, 0);
    @(posedge clock);
    ext <= 16'h3000;
    w(8);
    chk(pend, 16'h1000);
    chk(lvl[13:12], 0);
    @(posedge clock);
    clr <= 16'h1000;
    @(posedge clock);
    clr <= 0;
    w(1);
    chk(irq_any, 0);
    @(posedge clock);
    obs <= 16'h0010;
    for (int s = 3; s < 5; s++) begin
      cfg(9, FN_OBSERVE, IO_INPUT, 1, 0, s[3:0], 0);
      w(3);
      chk(oe_n[9], s == 4);
    end
    for (int r = 0; r < 4; r++) begin
      cfg(14, FN_PLAIN_IO, IO_LED, 1, 0, 0, r[1:0]);
      cnt = 0;
      @(negedge clock);
      prv = oe_n[14];
      repeat (64) begin
        @(negedge clock);
        cnt += int'(oe_n[14] !== prv);
        prv = oe_n[14];
      end
      chk(cnt >= (16 >> r) - 1 && cnt <= (16 >> r) + 1, 1);
    end
    @(posedge clock);
    m_sda <= 2'h2;
    s_sda <= 0;
    ext <= 16'h3008;
    cfg(6, FN_MODULE_TWI, IO_INPUT, 1, 0, 0, 0);
    w(6);
    chk(msda_in[0], 0);
    chk(ssda_in, 0);
    chk({oe_n[3], sscl_in}, 2'h2);
    @(posedge clock);
    m_scl <= 2'h1;
    alt <= 16'h7fff;
    ext <= 16'h3009;
    cfg(11, FN_MODULE_TWI, IO_INPUT, 1, 0, 0, 0);
    cfg(15, FN_ALT_A, IO_INPUT, 1, 0, 0, 0);
    w(6);
    chk(mscl_in, 2'h1);
    chk(oe_n[15], 0);
    chk(mabs, 0);
    // Move pin 2 away from its default, then reset in mid-run: the default must return.
    cfg(2, FN_PLAIN_IO, IO_INPUT, 1, 0, 0, 0);
    w(1);
    chk(fs[8:6], FN_PLAIN_IO);
    @(posedge clock);
    rst_n <= 0;
    repeat (2) @(posedge clock);
    rst_n <= 1;
    w(0);
    chk(fs[8:6], FN_SLAVE_TWI);
    chk(fs[11:9], FN_SLAVE_TWI);
    test_done();
  end
endmodule
`default_nettype wire
